// File: hdl/ift_encoder.sv
// Operation
// - Debug mode silences all trace output
// - First traced instruction sends full PC
// - Overflow stalls core or restarts trace
// - Valid low without traced instruction or message
// - Sequential instruction encoded as 0
// - Non-sequential target gets 10/11 prefix
// - Static taken branch encoded 10
// - Computed target encoded 11 plus address
// - Short offset record 0011 plus offset
// - Medium offset record 1011 plus offset
// - Full PC record 0111, PC, flag
// - Full PC on instruction set change
// - Sync counter forces periodic full PC
// - Discontinuity sends 1111 then full PC
// - Special modes only without normal trace
// - Illegal mode combination sets status bit
// - Match records carry 10-bit delta cycle count
// - 1023 idle cycles emit rollover message
// - Cycle counter halts during wait
// - One match record per triggerpoint match
// - Match mode excludes normal and other special modes, not cycle count
// - Match record field layout
// - Rollover message code 00
// - 57-bit bus, upper bits zero
// - Multiple matches report identifier 7
`timescale 1ns/1ns
`default_nettype none
`include "ift_defines.svh"
module ift_encoder
  import ift_pkg::*;
#(
  parameter int SYNC_W = `IFT_SYNC_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic trace_active_in_i,
  input wire logic normal_enable_i,
  input wire logic match_trace_enable_i,
  input wire logic cycle_count_enable_i,
  input wire logic other_special_enable_i,
  input wire logic overflow_stall_enable_i,
  input wire logic [SYNC_W-1:0] sync_period_i,
  input wire logic debug_mode_i,
  input wire logic wait_stopped_i,
  input wire logic retire_valid_i,
  input wire logic [31:0] retire_pc_i,
  input wire logic retire_ncc_i,
  input wire logic retire_branch_taken_i,
  input wire logic retire_static_target_i,
  input wire logic match_valid_i,
  input wire logic [3:0] match_hits_i,
  input wire logic [3:0] match_first_id_i,
  input wire logic match_inst_i,
  input wire logic buffer_ready_i,
  input wire logic buffer_overflow_i,
  output logic [`IFT_DATA_W-1:0] trace_data_o,
  output logic trace_valid_o,
  output logic stall_core_o,
  output logic illegal_o
);
  // Refuse sync counter widths the countdown cannot serve
  if (SYNC_W < 2 || SYNC_W > 16) begin : g_sync_w_check
    $error("SYNC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  ift_mode_t mode;
  wire trace_ok = !debug_mode_i && trace_active_in_i;
  wire bad_combo = (normal_enable_i && (match_trace_enable_i || cycle_count_enable_i
                   || other_special_enable_i))
                   || (match_trace_enable_i && other_special_enable_i);
  assign mode = bad_combo ? IFT_M_ILLEGAL :
                normal_enable_i ? IFT_M_NORMAL :
                match_trace_enable_i ? IFT_M_MATCH : IFT_M_OFF;
  wire norm_on = trace_ok && (mode == IFT_M_NORMAL);
  wire match_on = !debug_mode_i && (mode == IFT_M_MATCH);
  wire cyc_on = match_on && cycle_count_enable_i;

  ////////////////////////////////////////////////////////////////////////////
  // Normal mode state
  ift_state_t st_q, st_d;
  logic [31:0] last_pc_q;
  logic last_ncc_q;
  logic [SYNC_W-1:0] sync_q;
  logic illegal_q;

  // Signed offset fit check, used for both widths
  function automatic logic fits(input logic [31:0] d, input int bits);
    logic [31:0] hi;
    hi = $signed(d) >>> bits;
    return (hi == 32'h0) || (hi == 32'hFFFF_FFFF);
  endfunction

  wire [31:0] pc_offset = retire_pc_i - last_pc_q;
  wire fire = norm_on && retire_valid_i && !stall_core_o;
  wire isa_change = retire_ncc_i != last_ncc_q;
  wire sync_due = (sync_q == '0);
  wire need_full = isa_change || sync_due;
  wire ovf_drop = buffer_overflow_i && !overflow_stall_enable_i;

  // Record selection for a running instruction
  logic [`IFT_DATA_W-1:0] norm_word;
  always_comb begin
    norm_word = '0;
    if (st_q == IFT_S_RESUME) begin
      norm_word[3:0] = `IFT_CODE_RESUME;
    end else if (st_q == IFT_S_FULL || need_full) begin
      norm_word[3:0] = `IFT_CODE_FULL;
      norm_word[34:4] = retire_pc_i[31:1];
      norm_word[`IFT_FULL_NCC_BIT] = retire_ncc_i;
    end else if (!retire_branch_taken_i) begin
      norm_word[0] = `IFT_CODE_SEQ;
    end else if (retire_static_target_i) begin
      norm_word[1:0] = `IFT_CODE_BR;
    end else if (fits(pc_offset, 9)) begin
      norm_word[3:0] = `IFT_CODE_SHORT;
      norm_word[11:4] = pc_offset[8:1];
    end else if (fits(pc_offset, 17)) begin
      norm_word[3:0] = `IFT_CODE_MED;
      norm_word[19:4] = pc_offset[16:1];
    end else begin
      norm_word[3:0] = `IFT_CODE_FULL;
      norm_word[34:4] = retire_pc_i[31:1];
      norm_word[`IFT_FULL_NCC_BIT] = retire_ncc_i;
    end
  end

  // Sequencer: resume code, then full PC, then compact
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      IFT_S_IDLE: if (norm_on) st_d = IFT_S_FULL;
      IFT_S_RESUME: if (fire) st_d = IFT_S_FULL;
      IFT_S_FULL: if (fire) st_d = IFT_S_RUN;
      IFT_S_RUN: if (ovf_drop) st_d = IFT_S_RESUME;
    endcase
    if (!norm_on) st_d = IFT_S_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delta cycle counter
  logic [`IFT_CYC_W-1:0] cyc_cnt;
  logic cyc_roll;
  logic msg_out;
  wire match_fire = match_on && match_valid_i && (match_hits_i != 4'h0);
  assign msg_out = match_fire || cyc_roll;

  ift_cyc_counter u_cyc (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(cyc_on && !wait_stopped_i),
    .clear_i(!cyc_on || msg_out),
    .count_o(cyc_cnt),
    .roll_o(cyc_roll)
  );

  // Match record assembly
  wire multi_hit = (match_hits_i & (match_hits_i - 4'h1)) != 4'h0;
  logic [`IFT_DATA_W-1:0] bm_word;
  always_comb begin
    bm_word = '0;
    if (match_fire) begin
      bm_word[1:0] = `IFT_CODE_BM;
      bm_word[5:2] = multi_hit ? `IFT_MULTI_ID : match_first_id_i;
      bm_word[`IFT_BM_INST_BIT] = match_inst_i;
      bm_word[37:7] = retire_pc_i[31:1];
      bm_word[`IFT_BM_NCC_BIT] = retire_ncc_i;
      if (cycle_count_enable_i) bm_word[48:39] = cyc_cnt;
    end else begin
      bm_word[1:0] = `IFT_CODE_ROLL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q <= IFT_S_IDLE;
      last_pc_q <= '0;
      last_ncc_q <= 1'b1;
      sync_q <= '0;
      illegal_q <= 1'b0;
      stall_core_o <= 1'b0;
      trace_valid_o <= 1'b0;
      trace_data_o <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      illegal_q <= bad_combo;
      stall_core_o <= norm_on && overflow_stall_enable_i && !buffer_ready_i;
      trace_valid_o <= 1'b0;
      trace_data_o <= '0;
      if (fire && st_q != IFT_S_IDLE) begin
        trace_valid_o <= 1'b1;
        trace_data_o <= norm_word;
        if (st_q != IFT_S_RESUME) begin
          last_pc_q <= retire_pc_i;
          last_ncc_q <= retire_ncc_i;
          sync_q <= (st_q == IFT_S_FULL || need_full) ? sync_period_i : sync_q - 1'b1;
        end
      end else if (msg_out) begin
        trace_valid_o <= 1'b1;
        trace_data_o <= bm_word;
      end
    end
  end
  assign illegal_o = illegal_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Helper: a resume word went out and its full PC word is still due
  logic resume_open_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      resume_open_q <= 1'b0;
    end else if (ce_i && trace_valid_o) begin
      resume_open_q <= (trace_data_o[3:0] == `IFT_CODE_RESUME);
    end
  end

  // First word after a resume word
  sequence s_resume_then_full;
    trace_valid_o && resume_open_q;
  endsequence

  // A match taken on the previous enabled edge
  sequence s_match_taken;
    $past(match_fire) && $past(ce_i);
  endsequence

  a_debug_silent: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(debug_mode_i) && $past(ce_i) |-> !trace_valid_o) else $error("trace in debug");
  a_no_fire_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && !$past(fire) && !$past(msg_out) |-> !trace_valid_o)
    else $error("valid without event");
  a_resume_full: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_resume_then_full |-> trace_data_o[3:0] == `IFT_CODE_FULL)
    else $error("resume not followed by full pc");
  a_short_fmt: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    trace_valid_o && mode == IFT_M_NORMAL && trace_data_o[3:0] == `IFT_CODE_SHORT
    |-> trace_data_o[56:12] == '0) else $error("short record upper bits");
  a_full_ncc: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(fire) && $past(ce_i) && $past(st_q) == IFT_S_FULL
    |-> trace_data_o[3:0] == `IFT_CODE_FULL && trace_data_o[35] == $past(retire_ncc_i))
    else $error("full pc record wrong");
  a_illegal_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) |-> illegal_o == $past(bad_combo)) else $error("illegal flag wrong");
  a_multi_id: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(match_fire) && $past(multi_hit) && $past(ce_i) |-> trace_data_o[5:2] == 4'h7)
    else $error("multi match id");
  a_roll_code: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(cyc_roll) && !$past(match_fire) && $past(ce_i) |-> trace_valid_o
    && trace_data_o[1:0] == 2'b00 && trace_data_o[56:2] == '0) else $error("rollover code");
  a_seq_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(fire) && $past(st_q) == IFT_S_RUN && !$past(need_full)
    && !$past(retire_branch_taken_i) && $past(ce_i) |-> trace_data_o == '0)
    else $error("sequential not zero");

  // Full PC triggers at trace start and in the running state, and the resume word carries nothing else
  a_first_full: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(st_q) == IFT_S_IDLE && $past(norm_on) |-> st_q == IFT_S_FULL)
    else $error("no full pc after trace on");
  a_sync_full: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(fire) && $past(ce_i) && $past(st_q) == IFT_S_RUN && $past(sync_due)
    |-> trace_valid_o && trace_data_o[3:0] == `IFT_CODE_FULL) else $error("sync full pc missing");
  a_isa_full: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(fire) && $past(ce_i) && $past(st_q) == IFT_S_RUN && $past(isa_change)
    |-> trace_data_o[3:0] == `IFT_CODE_FULL && trace_data_o[35] == $past(retire_ncc_i))
    else $error("no full pc on isa change");
  a_resume_alone: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    trace_valid_o && trace_data_o[3:0] == `IFT_CODE_RESUME |-> trace_data_o[56:4] == '0)
    else $error("resume upper bits");

  // Stall and overflow
  a_stall_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(norm_on) && $past(overflow_stall_enable_i) && !$past(buffer_ready_i)
    |-> stall_core_o) else $error("core not stalled on full buffer");
  a_stall_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(stall_core_o) && !$past(msg_out) |-> !trace_valid_o)
    else $error("trace word during stall");
  a_drop_resume: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(norm_on) && $past(ovf_drop) && $past(st_q) == IFT_S_RUN
    |-> st_q == IFT_S_RESUME) else $error("overflow did not restart trace");

  // Mode exclusion
  a_illegal_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(mode) == IFT_M_ILLEGAL |-> !trace_valid_o)
    else $error("trace word in illegal mode");

  // Match records and cycle counter
  a_match_once: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_match_taken |-> trace_valid_o && trace_data_o[1:0] == `IFT_CODE_BM)
    else $error("match record missing");
  a_match_pc: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_match_taken |-> trace_data_o[37:7] == $past(retire_pc_i[31:1])
    && trace_data_o[56:49] == '0) else $error("match record layout");
  a_cyc_field: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_match_taken && $past(cyc_on) |-> trace_data_o[48:39] == $past(cyc_cnt))
    else $error("match record cycle count");
  a_roll_due: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(cyc_on) && !$past(wait_stopped_i) && $past(cyc_cnt) == `IFT_CYC_MAX
    |-> trace_valid_o) else $error("rollover message missing");
  a_wait_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(cyc_on) && $past(wait_stopped_i) && !$past(msg_out)
    |-> $stable(cyc_cnt)) else $error("cycle count moved in wait");
  a_roll_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(ce_i) && $past(msg_out) |-> cyc_cnt == 10'h001)
    else $error("cycle count not restarted");
endmodule // ift_encoder
`default_nettype wire

// File: hdl/ift_defines.svh
`ifndef IFT_DEFINES_SVH
`define IFT_DEFINES_SVH
// Trace bus width
`define IFT_DATA_W 57
// Normal mode record codes
`define IFT_CODE_SEQ 1'b0
`define IFT_CODE_BR 2'b01
`define IFT_CODE_SHORT 4'b0011
`define IFT_CODE_MED 4'b1011
`define IFT_CODE_FULL 4'b0111
`define IFT_CODE_RESUME 4'b1111
// Special mode record codes
`define IFT_CODE_ROLL 2'b00
`define IFT_CODE_BM 2'b01
// Field positions
`define IFT_BM_ID_LSB 2
`define IFT_BM_INST_BIT 6
`define IFT_BM_PC_LSB 7
`define IFT_BM_NCC_BIT 38
`define IFT_BM_CYC_LSB 39
`define IFT_FULL_NCC_BIT 35
// Counter widths and limits
`define IFT_CYC_W 10
`define IFT_CYC_MAX 10'h3FF
`define IFT_MULTI_ID 4'h7
`define IFT_SYNC_W 12
`define IFT_SYNC_RST 12'hFFF
`endif

// File: hdl/ift_pkg.sv
package ift_pkg;
  typedef enum logic [1:0] {
    IFT_M_OFF,
    IFT_M_NORMAL,
    IFT_M_MATCH,
    IFT_M_ILLEGAL
  } ift_mode_t;
  typedef enum {
    IFT_S_IDLE,
    IFT_S_RESUME,
    IFT_S_FULL,
    IFT_S_RUN
  } ift_state_t;
endpackage

// File: hdl/ift_cyc_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "ift_defines.svh"
// Delta cycle counter with rollover detection
module ift_cyc_counter (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic clear_i,
  output logic [`IFT_CYC_W-1:0] count_o,
  output logic roll_o
);
  logic [`IFT_CYC_W-1:0] cnt_q;
  // Rolls over after a full count without message
  assign roll_o = run_i && (cnt_q == `IFT_CYC_MAX);
  assign count_o = cnt_q;
  // Restart on message, hold in wait
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        cnt_q <= `IFT_CYC_W'(1);
      end else if (run_i) begin
        cnt_q <= cnt_q + `IFT_CYC_W'(1);
      end
    end
  end
endmodule // ift_cyc_counter
`default_nettype wire

// File: testbench/ift_tcb_model.sv
`timescale 1ns/1ns
`default_nettype none
// Trace control block stand-in: accepts words, can refuse room or drop data
module ift_tcb_model (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic trace_valid_i,
  input wire logic hold_i,
  input wire logic drop_i,
  output logic buffer_ready_o,
  output logic buffer_overflow_o,
  output int words_o
);
  // Room drops while held full; overflow is a one-cycle pulse
  always_ff @(posedge clk_sys_i) begin
    buffer_ready_o <= rst_b_i & ~hold_i;
    buffer_overflow_o <= rst_b_i & drop_i & ~buffer_overflow_o;
    if (!rst_b_i) begin
      words_o <= 0;
    end else if (trace_valid_i) begin
      words_o <= words_o + 1;
    end
  end
endmodule // ift_tcb_model
`default_nettype wire

// File: testbench/instruction_flow_trace_encoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ift_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module instruction_flow_trace_encoder_tb_top;
  logic clk_sys_i = 0, rst_b_i = 0, ce_i = 1, act = 0, nrm = 0, mt = 0, cyc = 0, oth = 0;
  logic stl = 0, dbg = 0, wt = 0, rv = 0, ncc = 1, br = 0, st = 0, mv = 0, mi = 0;
  logic hold = 0, drop = 0, rdy, ovf, tv, sc, ill;
  logic [11:0] sp = 12'hFFF;
  logic [31:0] pc = 32'h0;
  logic [3:0] hits = 4'h0, fid = 4'h0;
  logic [56:0] td;
  int fails = 0, total_checks = 0, words, n;
  always #2 clk_sys_i = ~clk_sys_i;
  ift_encoder dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .trace_active_in_i(act), .normal_enable_i(nrm), .match_trace_enable_i(mt),
    .cycle_count_enable_i(cyc), .other_special_enable_i(oth), .overflow_stall_enable_i(stl),
    .sync_period_i(sp), .debug_mode_i(dbg), .wait_stopped_i(wt), .retire_valid_i(rv),
    .retire_pc_i(pc), .retire_ncc_i(ncc), .retire_branch_taken_i(br),
    .retire_static_target_i(st), .match_valid_i(mv), .match_hits_i(hits),
    .match_first_id_i(fid), .match_inst_i(mi), .buffer_ready_i(rdy),
    .buffer_overflow_i(ovf), .trace_data_o(td), .trace_valid_o(tv), .stall_core_o(sc),
    .illegal_o(ill));
  ift_tcb_model tcb (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .trace_valid_i(tv),
    .hold_i(hold), .drop_i(drop), .buffer_ready_o(rdy), .buffer_overflow_o(ovf),
    .words_o(words));
  // One retired instruction, then check the answer one cycle later
  task automatic instr(input logic [31:0] p, input logic n1, b1, s1, ev, input logic [56:0] ed);
    @(posedge clk_sys_i) #1;
    {rv, pc, ncc, br, st} = {1'b1, p, n1, b1, s1};
    @(posedge clk_sys_i) #1;
    rv = 0;
    `CHK(tv, ev)
    if (ev) `CHK(td, ed)
  endtask
  // One triggerpoint match and its single record
  task automatic mtch(input logic [3:0] h, id, input logic [31:0] p, input logic [56:0] ed);
    @(posedge clk_sys_i) #1;
    {mv, hits, fid, mi, pc, ncc} = {1'b1, h, id, 1'b1, p, 1'b1};
    @(posedge clk_sys_i) #1;
    mv = 0;
    `CHK(tv, 1'b1)
    `CHK(td, ed)
    @(posedge clk_sys_i) #1;
    `CHK(tv, 1'b0)
  endtask
  function automatic logic [56:0] full(input logic [31:0] p, input logic n1);
    return {21'h0, n1, p[31:1], 4'h7};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    `CHK({tv, sc, ill, td}, 60'h0)
    rst_b_i = 1;
    {nrm, act} = 2'b11;
    instr(32'h1000, 1, 0, 0, 1, full(32'h1000, 1));
    instr(32'h1004, 1, 0, 0, 1, 57'h0);
    instr(32'h1008, 1, 0, 0, 1, 57'h0);
    instr(32'h1010, 1, 1, 1, 1, 57'h1);
    instr(32'h1030, 1, 1, 0, 1, {45'h0, 8'h10, 4'h3});
    instr(32'h3030, 1, 1, 0, 1, {37'h0, 16'h1000, 4'hB});
    instr(32'h3032, 0, 0, 0, 1, full(32'h3032, 0));
    instr(32'h3012, 0, 1, 0, 1, {45'h0, 8'hF0, 4'h3});
    @(posedge clk_sys_i) #1 rv = 0;
    $display("normal encodings done");
    @(posedge clk_sys_i) #1 drop = 1;
    @(posedge clk_sys_i) #1 drop = 0;
    instr(32'h3034, 0, 0, 0, 1, 57'hF);
    sp = 12'h002;
    instr(32'h3036, 0, 0, 0, 1, full(32'h3036, 0));
    n = 0;
    for (int i = 0; i < 6; i++) begin
      instr(32'h3038 + 2 * i, 0, 0, 0, 1,
        (i % 3 == 2) ? full(32'h3038 + 2 * i, 0) : 57'h0);
    end
    $display("sync done");
    dbg = 1;
    for (int i = 0; i < 4; i++) instr(32'h4000 + 2 * i, 0, 0, 0, 0, 57'h0);
    dbg = 0;
    instr(32'h5000, 1, 0, 0, 1, full(32'h5000, 1));
    {stl, hold} = 2'b11;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(sc, 1'b1)
    instr(32'h5004, 1, 0, 0, 0, 57'h0);
    hold = 0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(sc, 1'b0)
    ce_i = 0;
    instr(32'h5008, 1, 0, 0, 0, 57'h0);
    ce_i = 1;
    $display("stall done");
    mt = 1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(ill, 1'b1)
    {nrm, oth} = 2'b01;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(ill, 1'b1)
    oth = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(ill, 1'b0)
    mtch(4'h8, 4'h3, 32'h2000, {18'h0, 1'b1, 31'h1000, 1'b1, 4'h3, 2'b01});
    mtch(4'h6, 4'h1, 32'h2004, {18'h0, 1'b1, 31'h1002, 1'b1, 4'h7, 2'b01});
    $display("match done");
    cyc = 1;
    n = 0;
    @(posedge clk_sys_i) #1;
    while (!tv && n < 1100) begin
      @(posedge clk_sys_i) #1;
      n++;
    end
    `CHK(tv, 1'b1)
    `CHK(td, 57'h0)
    `CHK(n, 1022)
    $display("rollover done after %0d", n);
    mtch(4'h8, 4'h3, 32'h2000, {8'h0, 10'h002, 1'b1, 31'h1000, 1'b1, 4'h3, 2'b01});
    wt = 1;
    repeat (5) @(posedge clk_sys_i);
    #1 wt = 0;
    mtch(4'h4, 4'h2, 32'h2004, {8'h0, 10'h003, 1'b1, 31'h1002, 1'b1, 4'h2, 2'b01});
    `CHK(words, 22)
    $display("cycle count done");
    report_and_stop();
  end
  initial begin
    #80000;
    fails++;
    $display("[ERR] %0t run limit reached", $time);
    report_and_stop();
  end
endmodule // instruction_flow_trace_encoder_tb_top
`default_nettype wire
